/* rtl/rfc_pkg.sv */
// constants and types shared by the refresh controller
package rfc_pkg;
    // ---------------------------------------------
    // register indices, byte address is index * 4
    // ---------------------------------------------
    localparam logic [15:0] IDX_CONTROL = 16'hffac;
    localparam logic [15:0] IDX_CSR = 16'hffad;
    localparam logic [15:0] IDX_COUNT = 16'hffae;
    localparam logic [15:0] IDX_CONST = 16'hffaf;
    localparam logic [15:0] IDX_WAIT = 16'hffb0;
    // ---------------------------------------------
    // field positions
    // ---------------------------------------------
    localparam int CTL_SELF = 7;
    localparam int CTL_PSE = 6;
    localparam int CTL_DRE = 5;
    localparam int CTL_CAS = 4;
    localparam int CTL_M9 = 3;
    localparam int CTL_RFE = 2;
    localparam int CTL_RCY = 0;
    localparam int CSR_CMF = 7;
    localparam int CSR_CMIE = 6;
    localparam int CSR_CKS_HI = 5;
    localparam int CSR_CKS_LO = 3;
    localparam int WT_PIN = 2;
    // ---------------------------------------------
    // reset values and masks
    // ---------------------------------------------
    localparam logic [7:0] CONTROL_RST = 8'h02;
    localparam logic [7:0] CSR_RST = 8'h07;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CONST_RST = 8'hff;
    localparam logic [7:0] WAIT_RST = 8'h00;
    localparam logic [7:0] CONTROL_ONES = 8'h02;
    localparam logic [7:0] CSR_ONES = 8'h07;
    localparam logic [7:0] CTL_LOCK_MASK = 8'h1d;
    localparam logic [7:0] CTL_FREE_MASK = 8'he0;
    localparam logic [7:0] WAIT_MASK = 8'h07;
    localparam logic [2:0] CKS_STOP = 3'h0;
    // ---------------------------------------------
    // memory size limits as byte address widths
    // ---------------------------------------------
    localparam int ADDR_W_1M = 17;
    localparam int ADDR_W_16M = 21;
    // ---------------------------------------------
    // sequencer states
    // ---------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_ROW, ST_COL, ST_WAIT, ST_HOLD,
        ST_REF_CAS, ST_REF_RAS, ST_REF_HOLD, ST_SELF, ST_END
    } rfc_state_type;
    // low bits of the prescaler that must be all ones per select code
    function automatic logic [3:0] div_bits(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h0;
        unique case (sel)
            3'h1: r = 4'h1;
            3'h2: r = 4'h3;
            3'h3: r = 4'h5;
            3'h4: r = 4'h7;
            3'h5: r = 4'h9;
            3'h6: r = 4'hb;
            3'h7: r = 4'hc;
            3'h0: r = 4'h0;
        endcase
        return r;
    endfunction
endpackage

/* rtl/rfc_prescale.sv */
// clock prescaler producing one-cycle count ticks
`timescale 1ns/1ns
module rfc_prescale #(
    parameter int WIDTH = 12
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic run_in,
    input wire logic [2:0] sel_in,
    output logic tick_out
);
    logic [WIDTH-1:0] div;
    logic [3:0] need;
    logic [WIDTH-1:0] mask;
    logic tick_q;

    initial begin
        if (WIDTH < 12 || WIDTH > 15) begin
            $error("prescaler width must be 12 to 15");
        end
    end

    always_comb begin
        need = rfc_pkg::div_bits(sel_in);
        mask = WIDTH'((1 << need) - 1);
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div <= '0;
        end else if (run_in) begin
            div <= div + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tick_q <= 1'b0;
        end else if (run_in) begin
            tick_q <= (div & mask) == mask;
        end
    end

    // no stale tick once the select goes to stop
    assign tick_out = tick_q && sel_in != rfc_pkg::CKS_STOP;
endmodule

/* rtl/rfc_top.sv */
// refresh controller for area 3 dynamic or pseudo-static memory
//
// What this block does
// - memory attaches only on area 3
// - 1-Mbyte modes limit memory to 128 kbytes
// - 16-Mbyte modes limit memory to 2 Mbytes
// - one function: dynamic, pseudo-static, or timer
// - dynamic memory: dual column or dual write strobes
// - column address is 8 or 9 bits
// - software sets the refresh interval
// - software enables self-refresh in both refresh functions
// - wait states may stretch memory accesses
// - pseudo-static memory refreshed by refresh strobe
// - timer function: counter is 8-bit up-counter
// - seven clock dividers, 2 to 4096
// - counter matching constant can raise interrupt
// - refresh strobe low during each refresh cycle
// - upper strobe: upper write or upper column
// - lower strobe: lower write or lower column
// - read strobe: column strobe or write enable
// - area 3 select is the row strobe
// - area 3 memory uses own three-state timing
// - reset: control 02, timer status 07
// - reset: counter 00, constant FF
// - block can be halted to save power
// - enables pick function; both set is illegal
// - match flag sets on equality, read-then-write-zero clears
// - select zero stops counter, one to seven divide
// - memory enabled locks settings, match flag still clears
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
module rfc_top #(
    parameter int PRESCALE_W = 12
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic CE_IN,
    input wire logic MODULE_STOP_IN,
    input wire logic STANDBY_IN,
    input wire logic MODE_16M_IN,
    input wire logic WAIT_PIN_N_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [17:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic ACC_REQ_IN,
    input wire logic ACC_WE_IN,
    input wire logic [1:0] ACC_BE_IN,
    input wire logic [20:0] ACC_ADDR_IN,
    output logic ACC_DONE_OUT,
    output logic ACC_ERR_OUT,
    output logic [9:0] MEM_ADDR_OUT,
    output logic AREA3_SELECT_N_OUT,
    output logic UPPER_BYTE_STROBE_N_OUT,
    output logic LOWER_BYTE_STROBE_N_OUT,
    output logic READ_STROBE_N_OUT,
    output logic REFRESH_STROBE_N_OUT,
    output logic MATCH_INTERRUPT_OUT
);
    logic [7:0] control;
    logic [7:0] csr;
    logic [7:0] count;
    logic [7:0] constant;
    logic [7:0] wait_cfg;
    logic cmf_armed;
    logic [7:0] rd_data;
    logic hit_ctl, hit_csr, hit_cnt, hit_cor, hit_wt;
    logic wr_go, rd_go;
    logic mem_en, is_dram, is_ps, locked;
    logic tick, match, ref_pending, self_req;
    logic wait_s1, wait_s2;
    logic [1:0] wait_left;
    logic in_range, is_acc;
    rfc_pkg::rfc_state_type state;
    rfc_pkg::rfc_state_type next_state;
    logic [7:0] next_control;

    initial begin
        if (PRESCALE_W < 12) begin
            $error("prescaler too narrow for the largest divider");
        end
    end

    // ---------------------------------------------
    // register bus
    // ---------------------------------------------
    function automatic logic hit(input logic [17:0] adr, input logic [15:0] idx);
        return adr[17:2] == idx;
    endfunction

    always_comb begin
        hit_ctl = hit(WB_ADR_IN, rfc_pkg::IDX_CONTROL);
        hit_csr = hit(WB_ADR_IN, rfc_pkg::IDX_CSR);
        hit_cnt = hit(WB_ADR_IN, rfc_pkg::IDX_COUNT);
        hit_cor = hit(WB_ADR_IN, rfc_pkg::IDX_CONST);
        hit_wt = hit(WB_ADR_IN, rfc_pkg::IDX_WAIT);
        wr_go = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT && WB_SEL_IN[0];
        rd_go = WB_CYC_IN && WB_STB_IN && !WB_WE_IN && WB_ACK_OUT;
        is_dram = control[rfc_pkg::CTL_DRE] && !control[rfc_pkg::CTL_PSE];
        is_ps = control[rfc_pkg::CTL_PSE] && !control[rfc_pkg::CTL_DRE];
        mem_en = is_dram || is_ps;
        locked = control[rfc_pkg::CTL_DRE] || control[rfc_pkg::CTL_PSE];
        match = count == constant;
        rd_data = 8'h00;
        if (hit_ctl) begin
            rd_data = control | rfc_pkg::CONTROL_ONES;
        end else if (hit_csr) begin
            rd_data = csr | rfc_pkg::CSR_ONES;
        end else if (hit_cnt) begin
            rd_data = count;
        end else if (hit_cor) begin
            rd_data = constant;
        end else if (hit_wt) begin
            rd_data = wait_cfg;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= '0;
        end else if (CE_IN) begin
            WB_ACK_OUT <= WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
            WB_DAT_OUT <= {24'h00_0000, rd_data};
        end
    end

    // ---------------------------------------------
    // control register
    // ---------------------------------------------
    always_comb begin
        next_control = control;
        if (wr_go && hit_ctl) begin
            if (locked) begin
                next_control = (WB_DAT_IN[7:0] & rfc_pkg::CTL_FREE_MASK)
                             | (control & rfc_pkg::CTL_LOCK_MASK);
            end else begin
                next_control = WB_DAT_IN[7:0] & ~rfc_pkg::CONTROL_ONES;
            end
            if (next_control[rfc_pkg::CTL_PSE] && next_control[rfc_pkg::CTL_DRE]) begin
                next_control = control;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            control <= rfc_pkg::CONTROL_RST & ~rfc_pkg::CONTROL_ONES;
            wait_cfg <= rfc_pkg::WAIT_RST;
        end else if (CE_IN) begin
            control <= next_control;
            if (wr_go && hit_wt) begin
                wait_cfg <= WB_DAT_IN[7:0] & rfc_pkg::WAIT_MASK;
            end
        end
    end

    // ---------------------------------------------
    // timer status, counter, constant
    // ---------------------------------------------
    rfc_prescale #(
        .WIDTH(PRESCALE_W)
    ) u_prescale (
        .clk_in(CLK_SYS_IN),
        .reset_in(RESET_IN),
        .run_in(CE_IN && !MODULE_STOP_IN),
        .sel_in(csr[rfc_pkg::CSR_CKS_HI:rfc_pkg::CSR_CKS_LO]),
        .tick_out(tick)
    );

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            csr <= rfc_pkg::CSR_RST & ~rfc_pkg::CSR_ONES;
            cmf_armed <= 1'b0;
        end else if (CE_IN) begin
            if (rd_go && hit_csr && csr[rfc_pkg::CSR_CMF]) begin
                cmf_armed <= 1'b1;
            end
            if (wr_go && hit_csr && !locked) begin
                csr[rfc_pkg::CSR_CKS_HI:rfc_pkg::CSR_CKS_LO] <=
                    WB_DAT_IN[rfc_pkg::CSR_CKS_HI:rfc_pkg::CSR_CKS_LO];
                csr[rfc_pkg::CSR_CMIE] <= WB_DAT_IN[rfc_pkg::CSR_CMIE];
            end
            if (locked) begin
                csr[rfc_pkg::CSR_CMIE] <= 1'b0;
            end
            // set wins over the clear
            if (tick && match && !MODULE_STOP_IN) begin
                csr[rfc_pkg::CSR_CMF] <= 1'b1;
            end else if (wr_go && hit_csr && cmf_armed && !WB_DAT_IN[rfc_pkg::CSR_CMF]) begin
                csr[rfc_pkg::CSR_CMF] <= 1'b0;
                cmf_armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            count <= rfc_pkg::COUNT_RST;
            constant <= rfc_pkg::CONST_RST;
        end else if (CE_IN) begin
            if (wr_go && hit_cor && !locked) begin
                constant <= WB_DAT_IN[7:0];
            end
            if (wr_go && hit_cnt && !locked) begin
                count <= WB_DAT_IN[7:0];
            end else if (tick && !MODULE_STOP_IN) begin
                count <= match ? rfc_pkg::COUNT_RST : count + 8'h01;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            MATCH_INTERRUPT_OUT <= 1'b0;
            ref_pending <= 1'b0;
        end else if (CE_IN) begin
            MATCH_INTERRUPT_OUT <= csr[rfc_pkg::CSR_CMF] && csr[rfc_pkg::CSR_CMIE];
            if (tick && match && !MODULE_STOP_IN && mem_en && control[rfc_pkg::CTL_RCY]) begin
                ref_pending <= 1'b1;
            end else if (next_state == rfc_pkg::ST_REF_CAS || !mem_en) begin
                ref_pending <= 1'b0;
            end
        end
    end

    // ---------------------------------------------
    // area 3 sequencer
    // ---------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            wait_s1 <= 1'b1;
            wait_s2 <= 1'b1;
        end else if (CE_IN) begin
            wait_s1 <= WAIT_PIN_N_IN;
            wait_s2 <= wait_s1;
        end
    end

    always_comb begin
        self_req = STANDBY_IN && control[rfc_pkg::CTL_SELF] && mem_en;
        in_range = (ACC_ADDR_IN >> (MODE_16M_IN ? rfc_pkg::ADDR_W_16M : rfc_pkg::ADDR_W_1M)) == '0;
        next_state = state;
        unique case (state)
            rfc_pkg::ST_IDLE: begin
                if (self_req) begin
                    next_state = rfc_pkg::ST_SELF;
                end else if (ref_pending) begin
                    next_state = rfc_pkg::ST_REF_CAS;
                end else if (ACC_REQ_IN && !ACC_DONE_OUT) begin // done high: request already served
                    next_state = (mem_en && in_range) ? rfc_pkg::ST_ROW : rfc_pkg::ST_END;
                end
            end
            rfc_pkg::ST_ROW: next_state = rfc_pkg::ST_COL;
            rfc_pkg::ST_COL: next_state = wait_left != 2'h0 ? rfc_pkg::ST_WAIT : rfc_pkg::ST_HOLD;
            rfc_pkg::ST_WAIT: begin
                if (wait_left == 2'h0 && (wait_s2 || !wait_cfg[rfc_pkg::WT_PIN])) begin
                    next_state = rfc_pkg::ST_HOLD;
                end
            end
            rfc_pkg::ST_HOLD: next_state = rfc_pkg::ST_END;
            rfc_pkg::ST_REF_CAS: next_state = rfc_pkg::ST_REF_RAS;
            rfc_pkg::ST_REF_RAS: next_state = rfc_pkg::ST_REF_HOLD;
            rfc_pkg::ST_REF_HOLD: next_state = rfc_pkg::ST_END;
            rfc_pkg::ST_SELF: next_state = self_req ? rfc_pkg::ST_SELF : rfc_pkg::ST_END;
            rfc_pkg::ST_END: next_state = rfc_pkg::ST_IDLE;
            default: next_state = rfc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            state <= rfc_pkg::ST_IDLE;
            wait_left <= 2'h0;
            is_acc <= 1'b0;
        end else if (CE_IN) begin
            state <= next_state;
            if (state == rfc_pkg::ST_IDLE) begin
                wait_left <= wait_cfg[1:0];
                is_acc <= next_state == rfc_pkg::ST_ROW || next_state == rfc_pkg::ST_END;
            end else if (state == rfc_pkg::ST_WAIT && wait_left != 2'h0) begin
                wait_left <= wait_left - 2'h1;
            end
        end
    end

    // ---------------------------------------------
    // memory pins
    // ---------------------------------------------
    logic acc_ph, cas_ph, ref_cas, ref_ras, ref_any;
    logic [19:0] word;
    always_comb begin
        word = ACC_ADDR_IN[20:1];
        acc_ph = state inside {rfc_pkg::ST_ROW, rfc_pkg::ST_COL, rfc_pkg::ST_WAIT, rfc_pkg::ST_HOLD};
        cas_ph = state inside {rfc_pkg::ST_COL, rfc_pkg::ST_WAIT, rfc_pkg::ST_HOLD};
        ref_any = state inside {rfc_pkg::ST_REF_CAS, rfc_pkg::ST_REF_RAS, rfc_pkg::ST_REF_HOLD,
                                rfc_pkg::ST_SELF};
        ref_cas = is_dram && ref_any;
        ref_ras = is_dram && (ref_any && state != rfc_pkg::ST_REF_CAS);
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            MEM_ADDR_OUT <= '0;
            AREA3_SELECT_N_OUT <= 1'b1;
            UPPER_BYTE_STROBE_N_OUT <= 1'b1;
            LOWER_BYTE_STROBE_N_OUT <= 1'b1;
            READ_STROBE_N_OUT <= 1'b1;
            REFRESH_STROBE_N_OUT <= 1'b1;
            ACC_DONE_OUT <= 1'b0;
            ACC_ERR_OUT <= 1'b0;
        end else if (CE_IN) begin
            if (state == rfc_pkg::ST_ROW) begin
                MEM_ADDR_OUT <= control[rfc_pkg::CTL_M9] ? word[18:9] : {word[17:8]};
            end else begin
                MEM_ADDR_OUT <= control[rfc_pkg::CTL_M9] ? {1'b0, word[8:0]} : {2'b00, word[7:0]};
            end
            AREA3_SELECT_N_OUT <= !(acc_ph || ref_ras);
            REFRESH_STROBE_N_OUT <= !(ref_any && control[rfc_pkg::CTL_RFE]);
            if (is_dram && control[rfc_pkg::CTL_CAS]) begin
                UPPER_BYTE_STROBE_N_OUT <= !(cas_ph && ACC_BE_IN[1] || ref_cas);
                LOWER_BYTE_STROBE_N_OUT <= !(cas_ph && ACC_BE_IN[0] || ref_cas);
                READ_STROBE_N_OUT <= !(cas_ph && ACC_WE_IN);
            end else begin
                UPPER_BYTE_STROBE_N_OUT <= !(cas_ph && ACC_WE_IN && ACC_BE_IN[1]);
                LOWER_BYTE_STROBE_N_OUT <= !(cas_ph && ACC_WE_IN && ACC_BE_IN[0]);
                READ_STROBE_N_OUT <= !(is_dram ? (cas_ph || ref_cas) : (cas_ph && !ACC_WE_IN));
            end
            ACC_DONE_OUT <= state == rfc_pkg::ST_END && is_acc;
            ACC_ERR_OUT <= state == rfc_pkg::ST_END && is_acc && !mem_en;
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    property p_reset_vals;
        @(posedge CLK_SYS_IN) $past(RESET_IN) && !RESET_IN |->
            (control | rfc_pkg::CONTROL_ONES) == rfc_pkg::CONTROL_RST &&
            (csr | rfc_pkg::CSR_ONES) == rfc_pkg::CSR_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("control reset value wrong");

    property p_reset_cnt;
        @(posedge CLK_SYS_IN) $past(RESET_IN) && !RESET_IN |->
            count == rfc_pkg::COUNT_RST && constant == rfc_pkg::CONST_RST;
    endproperty
    a_reset_cnt: assert property (p_reset_cnt) else $error("counter reset value wrong");

    property p_no_both;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN)
            !(control[rfc_pkg::CTL_PSE] && control[rfc_pkg::CTL_DRE]);
    endproperty
    a_no_both: assert property (p_no_both) else $error("both memory enables set");

    property p_lock;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN || !CE_IN)
            locked && wr_go |=> (control & rfc_pkg::CTL_LOCK_MASK) ==
                ($past(control) & rfc_pkg::CTL_LOCK_MASK) && $stable(constant);
    endproperty
    a_lock: assert property (p_lock) else $error("locked setting changed");

    property p_cmf_set;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN || !CE_IN)
            tick && match && !MODULE_STOP_IN |=> csr[rfc_pkg::CSR_CMF] ##1
                MATCH_INTERRUPT_OUT == $past(csr[rfc_pkg::CSR_CMIE]);
    endproperty
    a_cmf_set: assert property (p_cmf_set) else $error("match flag not set");

    property p_stop;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN || !CE_IN)
            csr[rfc_pkg::CSR_CKS_HI:rfc_pkg::CSR_CKS_LO] == rfc_pkg::CKS_STOP && !(wr_go && hit_cnt)
                |=> $stable(count);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_access;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN || !CE_IN)
            state == rfc_pkg::ST_ROW |=> state == rfc_pkg::ST_COL ##1 !AREA3_SELECT_N_OUT;
    endproperty
    a_access: assert property (p_access) else $error("access sequence wrong");

    property p_cbr;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN || !CE_IN)
            state == rfc_pkg::ST_REF_CAS && is_dram |=> AREA3_SELECT_N_OUT ##1 !AREA3_SELECT_N_OUT;
    endproperty
    a_cbr: assert property (p_cbr) else $error("row strobe before column strobe");

    property p_refresh_strobe;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN || !CE_IN)
            state == rfc_pkg::ST_REF_CAS && control[rfc_pkg::CTL_RFE] |=> !REFRESH_STROBE_N_OUT[*3];
    endproperty
    a_refresh_strobe: assert property (p_refresh_strobe) else $error("refresh strobe not low");

    property p_wait;
        @(posedge CLK_SYS_IN) disable iff (RESET_IN || !CE_IN)
            state == rfc_pkg::ST_COL && wait_left != 2'h0 |=> state == rfc_pkg::ST_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state skipped");
endmodule

/* tb/rfc_mem_model.sv */
// far-side dynamic memory model watching the strobes
`timescale 1ns/1ns
module rfc_mem_model (
    input wire logic clk_in,
    input wire logic ras_n_in,
    input wire logic ucas_n_in,
    input wire logic lcas_n_in,
    input wire logic refresh_strobe_n_in,
    input wire logic slow_in,
    input wire logic cas_n_in,
    input wire logic [9:0] addr_in,
    output logic [9:0] row_out,
    output logic wait_n_out,
    output int refresh_count_out,
    output int bad_count_out
);
    logic ras_q;
    int hold;
    initial begin
        ras_q = 1'b1;
        hold = 0;
        wait_n_out = 1'b1;
        row_out = '0;
        refresh_count_out = 0;
        bad_count_out = 0;
    end
    // ----------------------------------
    // row strobe fall: refresh or access
    // ----------------------------------
    always @(posedge clk_in) begin
        ras_q <= ras_n_in;
        wait_n_out <= (hold == 0);
        if (hold > 0) begin
            hold <= hold - 1;
        end
        if (ras_q === 1'b1 && ras_n_in === 1'b0) begin
            if (ucas_n_in === 1'b0 || lcas_n_in === 1'b0 || cas_n_in === 1'b0) begin
                refresh_count_out <= refresh_count_out + 1;
                if (refresh_strobe_n_in !== 1'b0) begin
                    bad_count_out <= bad_count_out + 1;
                end
            end else begin
                row_out <= addr_in;
                if (slow_in) begin
                    hold <= 3;
                end
            end
        end
    end
endmodule

/* tb/test_rfc_top.sv */
// self-checking bench for the refresh controller
`timescale 1ns/1ns
module test_rfc_top;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, awe = 1'b0, slow = 1'b0;
    logic [17:0] adr = 18'h0_0000;
    logic [31:0] dat = 32'h0000_0000, rdat;
    logic [20:0] aadr = 21'h00_0000;
    logic ack, done, err, cs_n, u_n, l_n, rd_n, rf_n, irq, wt_n;
    logic [9:0] maddr, row;
    logic [3:0] sel = 4'h1;
    logic [1:0] be = 2'b11;
    logic [7:0] rdq[$];
    logic errq[$];
    logic [31:0] seed = 32'hd254_910a;
    logic [7:0] k;
    int mismatches = 0, checks = 0, cyc_n = 0, refs, bads;
    always #50 clk = ~clk;
    rfc_top #(.PRESCALE_W(12)) u_rfc_top (.CLK_SYS_IN(clk), .RESET_IN(rst), .CE_IN(1'b1),
        .MODULE_STOP_IN(1'b0), .STANDBY_IN(1'b0), .MODE_16M_IN(1'b1), .WAIT_PIN_N_IN(wt_n),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .ACC_REQ_IN(req), .ACC_WE_IN(awe),
        .ACC_BE_IN(be), .ACC_ADDR_IN(aadr), .ACC_DONE_OUT(done), .ACC_ERR_OUT(err),
        .MEM_ADDR_OUT(maddr), .AREA3_SELECT_N_OUT(cs_n), .UPPER_BYTE_STROBE_N_OUT(u_n),
        .LOWER_BYTE_STROBE_N_OUT(l_n), .READ_STROBE_N_OUT(rd_n), .REFRESH_STROBE_N_OUT(rf_n),
        .MATCH_INTERRUPT_OUT(irq));
    rfc_mem_model u_rfc_mem_model (.clk_in(clk), .ras_n_in(cs_n), .ucas_n_in(u_n), .lcas_n_in(l_n),
        .refresh_strobe_n_in(rf_n), .slow_in(slow), .cas_n_in(rd_n), .addr_in(maddr), .row_out(row),
        .wait_n_out(wt_n), .refresh_count_out(refs),
        .bad_count_out(bads));
    // ----------------------------------
    // helpers
    // ----------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic wb(input logic [15:0] idx, input logic w, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h00_0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        rdq.push_back(e);
        wb(idx, 1'b0, 8'h00);
    endtask
    task automatic acc(input logic e);
        errq.push_back(e);
        seed = xs(seed);
        @(posedge clk);
        req <= 1'b1;
        awe <= seed[0];
        be <= seed[18:17];
        aadr <= {4'h0, seed[16:0]};
        do @(posedge clk); while (done !== 1'b1);
        req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----------------------------------
    // result watcher and timeout
    // ----------------------------------
    always @(posedge clk) begin
        cyc_n++;
        if (ack === 1'b1 && we === 1'b0 && rdq.size() > 0) begin
            chk("read data", rdq.pop_front(), rdat[7:0]);
        end
        if (done === 1'b1 && errq.size() > 0) begin
            chk("access error", {7'h00, errq.pop_front()}, {7'h00, err});
        end
        if (cyc_n == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    // ----------------------------------
    // main sequence
    // ----------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(rfc_pkg::IDX_CONTROL, 8'h02);
        rd(rfc_pkg::IDX_CSR, 8'h07);
        rd(rfc_pkg::IDX_COUNT, 8'h00);
        rd(rfc_pkg::IDX_CONST, 8'hff);
        rd(16'hffb4, 8'h00);
        seed = xs(seed);
        k = seed[7:0];
        wb(rfc_pkg::IDX_COUNT, 1'b1, k);
        rd(rfc_pkg::IDX_COUNT, k);
        acc(1'b1);
        wb(rfc_pkg::IDX_COUNT, 1'b1, 8'h00);
        wb(rfc_pkg::IDX_CONST, 1'b1, 8'h03);
        sel <= 4'h0;
        wb(rfc_pkg::IDX_CONST, 1'b1, 8'h55);
        sel <= 4'h1;
        wb(rfc_pkg::IDX_CSR, 1'b1, 8'h48);
        while (irq !== 1'b1) @(posedge clk);
        wb(rfc_pkg::IDX_CSR, 1'b1, 8'hc0);
        rd(rfc_pkg::IDX_CSR, 8'hc7);
        wb(rfc_pkg::IDX_CSR, 1'b1, 8'h40);
        repeat (3) @(posedge clk);
        chk("interrupt", 8'h00, {7'h00, irq});
        rd(rfc_pkg::IDX_CSR, 8'h47);
        wb(rfc_pkg::IDX_CSR, 1'b1, 8'h08);
        wb(rfc_pkg::IDX_CONTROL, 1'b1, 8'h05);
        wb(rfc_pkg::IDX_CONTROL, 1'b1, 8'h65);
        rd(rfc_pkg::IDX_CONTROL, 8'h07);
        wb(rfc_pkg::IDX_CONTROL, 1'b1, 8'h25);
        wb(rfc_pkg::IDX_CONST, 1'b1, 8'h00);
        rd(rfc_pkg::IDX_CONST, 8'h03);
        rd(rfc_pkg::IDX_CONTROL, 8'h27);
        wb(rfc_pkg::IDX_WAIT, 1'b1, 8'h05);
        slow <= 1'b1;
        acc(1'b0);
        while (refs < 2) @(posedge clk);
        acc(1'b0);
        chk("row address", aadr[16:9], row[7:0]);
        chk("refresh strobe", 8'h00, bads[7:0]);
        stop_test();
    end
endmodule
